// ### remote_local_ctrl.sv
/*
  Remote/local control of a bus-attached instrument: remote and
  lockout state, addressing lamps, device clear, trigger, serial
  poll and master/slave role.
  Assumes a bus protocol engine on the same clock that gives
  one-cycle pulses for decoded commands; REN, IFC and panel keys
  arrive from pins and are synchronised here.
*/
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module remote_local_ctrl import remote_local_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Bus lines from pins
  input wire logic ren_i,
  input wire logic ifc_i,
  // Decoded bus commands, one-cycle pulses
  input wire logic mla_i,
  input wire logic mta_i,
  input wire logic unl_i,
  input wire logic unt_i,
  input wire logic cmd_llo_i,
  input wire logic cmd_gtl_i,
  input wire logic cmd_dcl_i,
  input wire logic cmd_sdc_i,
  input wire logic cmd_get_i,
  input wire logic spoll_req_i,
  input wire logic [7:0] spoll_status_i,
  // Master/slave loop
  input wire logic ms_init_i,
  // Front panel pins
  input wire logic local_key_i,
  input wire logic [7:0] panel_keys_i,
  // Outputs
  output logic remote_o,
  output logic lockout_o,
  output logic talk_o,
  output logic listen_o,
  output logic [7:0] keys_o,
  output logic disp_norm_o,
  output logic defaults_o,
  output logic slave_clr_o,
  output logic trig_o,
  output logic [7:0] spoll_byte_o,
  output logic spoll_vld_o,
  output logic [4:0] bus_addr_o,
  output logic [2:0] trig_src_o,
  output logic fmt_o,
  output logic [1:0] role_o
);

  //------------------------------------------------------------
  // State
  //------------------------------------------------------------
  typedef struct packed {
    logic ren_m;         // Synchroniser stages
    logic ren_s;
    logic ifc_m;
    logic ifc_s;
    logic lk_m;
    logic lk_s;
    logic lk_d;          // Delayed key for edge
    logic [7:0] keys_m;
    logic [7:0] keys_s;
    logic remote;
    logic lockout;
    logic talk;
    logic listen;
    logic msg_on;        // User message on display
    role_t role;
    logic [4:0] addr;
    logic [2:0] trig_src;
    logic fmt;
    logic cfg_master;
    logic [7:0] keys_out;
    logic disp_norm;
    logic defaults;
    logic slave_clr;
    logic trig;
    logic [7:0] spoll_byte;
    logic spoll_vld;
    logic [31:0] rdata;
  } state_t;

  state_t r;       // Registered state
  state_t next_r;  // Next state
  logic lk_edge;   // Local key press
  logic key_ok;    // Press accepted
  logic clr;       // Device clear applies
  logic restore;   // Factory restore write

  //------------------------------------------------------------
  // Next-state logic
  //------------------------------------------------------------
  always_comb begin
    next_r = r;
    // Pulses last one cycle
    next_r.disp_norm = 1'b0;
    next_r.defaults = 1'b0;
    next_r.slave_clr = 1'b0;
    next_r.trig = 1'b0;
    next_r.spoll_vld = 1'b0;
    next_r.rdata = 32'h0;
    // Pin synchronisers; first stage feeds only the second
    next_r.ren_m = ren_i;
    next_r.ren_s = r.ren_m;
    next_r.ifc_m = ifc_i;
    next_r.ifc_s = r.ifc_m;
    next_r.lk_m = local_key_i;
    next_r.lk_s = r.lk_m;
    next_r.lk_d = r.lk_s;
    next_r.keys_m = panel_keys_i;
    next_r.keys_s = r.keys_m;
    lk_edge = r.lk_s & ~r.lk_d;
    key_ok = lk_edge & ~r.lockout;
    clr = cmd_dcl_i | (cmd_sdc_i & r.listen);
    restore = wr_i && addr_i == OFS_CMD && wdata_i[CMD_RESTORE_BIT];

    // Panel keys pass only in local without lockout
    next_r.keys_out = (r.remote | r.lockout) ? 8'h00 : r.keys_s;

    // Addressing; talk works in either remote state
    if (unt_i) begin
      next_r.talk = 1'b0;
    end
    if (unl_i) begin
      next_r.listen = 1'b0;
    end
    if (mta_i) begin
      next_r.talk = 1'b1;
      next_r.listen = 1'b0;
    end
    if (mla_i) begin
      next_r.listen = 1'b1;
      next_r.talk = 1'b0;
    end

    // Remote: clears first, listen address with REN wins over them
    if (cmd_gtl_i || key_ok || !r.ren_s) begin
      next_r.remote = 1'b0;
    end
    if (mla_i && r.ren_s) begin
      next_r.remote = 1'b1;
    end

    // Lockout needs REN; only REN false ends it
    if (!r.ren_s) begin
      next_r.lockout = 1'b0;
    end else if (cmd_llo_i) begin
      next_r.lockout = 1'b1;
    end

    // Accepted key restores the display
    if (key_ok && r.msg_on) begin
      next_r.disp_norm = 1'b1;
    end
    if (key_ok || clr || restore) begin
      next_r.msg_on = 1'b0;
    end

    // Register writes
    if (wr_i) begin
      case (addr_i)
        OFS_CTRL: begin
          next_r.addr = wdata_i[CTRL_ADDR_LO +: 5];
          next_r.trig_src = wdata_i[CTRL_TRIG_LO +: 3];
          next_r.fmt = wdata_i[CTRL_FMT_BIT];
          next_r.cfg_master = wdata_i[CTRL_MSTR_BIT];
        end
        OFS_CMD: begin
          if (wdata_i[CMD_MSG_OFF_BIT]) begin
            next_r.msg_on = 1'b0;
            next_r.disp_norm = r.msg_on;
          end
          // Set wins over any clear this cycle
          if (wdata_i[CMD_MSG_ON_BIT]) begin
            next_r.msg_on = 1'b1;
          end
        end
        default: begin
          // Other offsets ignore writes
        end
      endcase
    end

    // Defaults; address and role left alone on purpose
    if (clr || restore) begin
      next_r.trig_src = RST_TRIG_SRC;
      next_r.fmt = FULL_SINGLE_TALK_FORMAT;
    end
    if (clr) begin
      next_r.defaults = 1'b1;
      next_r.slave_clr = 1'b1;
    end

    // Trigger only from the GET source
    next_r.trig = cmd_get_i && r.listen && r.trig_src == TRIG_SRC_GET;

    // Serial poll answered regardless of service request
    if (spoll_req_i) begin
      next_r.spoll_byte = spoll_status_i;
      next_r.spoll_vld = 1'b1;
    end

    // Role; clears never touch it
    case (r.role)
      ROLE_STANDALONE: begin
        if (r.cfg_master) begin
          next_r.role = ROLE_MASTER;
        end else if (ms_init_i) begin
          next_r.role = ROLE_SLAVE;
        end
      end
      ROLE_SLAVE: begin
        if (r.cfg_master) begin
          next_r.role = ROLE_MASTER;
        end
      end
      ROLE_MASTER: begin
        if (!r.cfg_master) begin
          next_r.role = ROLE_STANDALONE;
        end
      end
      default: begin
        next_r.role = ROLE_STANDALONE;
      end
    endcase

    // IFC overrides everything addressed
    if (r.ifc_s) begin
      next_r.remote = 1'b0;
      next_r.talk = 1'b0;
      next_r.listen = 1'b0;
    end

    // Register reads, data in the next cycle
    if (rd_i) begin
      case (addr_i)
        OFS_CTRL: begin
          next_r.rdata = {22'h0, r.cfg_master, r.fmt, r.trig_src, r.addr};
        end
        OFS_STATUS: begin
          next_r.rdata = {25'h0, r.role, r.msg_on, r.listen, r.talk,
                          r.lockout, r.remote};
        end
        OFS_SPOLL: begin
          next_r.rdata = {24'h0, r.spoll_byte};
        end
        default: begin
          next_r.rdata = 32'h0; // Unmapped reads zero
        end
      endcase
    end
  end

  //------------------------------------------------------------
  // State register
  //------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      r <= '0;
      r.role <= ROLE_STANDALONE;
      r.addr <= RST_BUS_ADDR;
      r.trig_src <= RST_TRIG_SRC;
      r.fmt <= FULL_SINGLE_TALK_FORMAT;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  assign rdata_o = r.rdata;
  assign remote_o = r.remote;
  assign lockout_o = r.lockout;
  assign talk_o = r.talk;
  assign listen_o = r.listen;
  assign keys_o = r.keys_out;
  assign disp_norm_o = r.disp_norm;
  assign defaults_o = r.defaults;
  assign slave_clr_o = r.slave_clr;
  assign trig_o = r.trig;
  assign spoll_byte_o = r.spoll_byte;
  assign spoll_vld_o = r.spoll_vld;
  assign bus_addr_o = r.addr;
  assign trig_src_o = r.trig_src;
  assign fmt_o = r.fmt;
  assign role_o = r.role;

  //------------------------------------------------------------
  // Assertions
  //------------------------------------------------------------
  AST_LOCAL_KEY: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (r.lk_s && !r.lk_d && !lockout_o && !mla_i) |=> !remote_o)
    else $error("local key did not leave remote");
  AST_LOCKED_KEY: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (r.lk_s && !r.lk_d && lockout_o && remote_o && r.ren_s && !cmd_gtl_i
     && !r.ifc_s) |=> remote_o)
    else $error("local key acted under lockout");
  AST_KEYS_GATED: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (remote_o || lockout_o) |=> keys_o == 8'h00)
    else $error("panel key passed while blocked");
  AST_MSG_CLEAR: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (r.lk_s && !r.lk_d && !lockout_o && r.msg_on && !wr_i) |=> disp_norm_o && !r.msg_on)
    else $error("display not restored by local key");
  AST_REMOTE_CAUSE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(remote_o) |-> $past(mla_i) && $past(r.ren_s))
    else $error("remote entered without listen and REN");
  AST_IFC: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    r.ifc_s |=> !remote_o && !talk_o && !listen_o)
    else $error("IFC left device addressed");
  AST_GTL: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_gtl_i && !mla_i) |=> !remote_o)
    else $error("GTL did not leave remote");
  AST_REN_LOW: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !r.ren_s |=> !lockout_o && !remote_o)
    else $error("REN false kept lockout or remote");
  AST_LOCK_HOLD: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (lockout_o && r.ren_s) |=> lockout_o)
    else $error("lockout dropped with REN true");
  AST_DCL: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_dcl_i && !wr_i && !ms_init_i) |=> defaults_o && slave_clr_o
      && $stable(bus_addr_o) && $stable(role_o) && trig_src_o == RST_TRIG_SRC)
    else $error("device clear wrong");
  AST_SDC: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_sdc_i && !cmd_dcl_i) |=> defaults_o == $past(listen_o))
    else $error("selective clear ignored addressing");
  AST_GET: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    cmd_get_i |=> trig_o == ($past(listen_o) && $past(trig_src_o) == TRIG_SRC_GET))
    else $error("GET trigger wrong");
  AST_SPOLL: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    spoll_req_i |=> spoll_vld_o && spoll_byte_o == $past(spoll_status_i))
    else $error("serial poll not answered");
  AST_TALK: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (mta_i && !mla_i && !r.ifc_s) |=> talk_o && !listen_o)
    else $error("talk address not taken");
  AST_RESTORE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (wr_i && addr_i == OFS_CMD && wdata_i[CMD_RESTORE_BIT]) |=> $stable(bus_addr_o)
      && fmt_o == FULL_SINGLE_TALK_FORMAT)
    else $error("restore changed address");
  AST_SLAVE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (role_o == ROLE_SLAVE && $past(role_o) != ROLE_SLAVE) |-> $past(ms_init_i))
    else $error("slave without loop init");

  // Lockout is taken on LLO whenever REN is true
  AST_LLO_SET: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_llo_i && r.ren_s) |=> lockout_o)
    else $error("lockout not taken");
  // Remote never appears without the listener lamp
  AST_REMOTE_LISTEN: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(remote_o) |-> listen_o)
    else $error("remote entered without listening");
  // Any accepted clear restores format and trigger defaults
  AST_CLR_FMT: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_dcl_i || (cmd_sdc_i && listen_o)) |=> fmt_o == FULL_SINGLE_TALK_FORMAT && trig_src_o == RST_TRIG_SRC)
    else $error("clear left format or trigger");
  // Role settled against config must survive a clear
  AST_CLR_ROLE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ((cmd_dcl_i || (cmd_sdc_i && listen_o)) && !ms_init_i && ((role_o == ROLE_MASTER) == r.cfg_master))
      |=> $stable(role_o) && slave_clr_o)
    else $error("clear changed role or missed slaves");
  // Clears never touch the programmed address
  AST_CLR_ADDR: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ((cmd_dcl_i || cmd_sdc_i) && !wr_i) |=> $stable(bus_addr_o))
    else $error("clear changed bus address");
  // REN false always ends remote
  AST_REN_REMOTE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !r.ren_s |=> !remote_o)
    else $error("remote kept with REN false");
  // Talking needs no remote state
  AST_TALK_LOCAL: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (mta_i && !mla_i && !r.ifc_s && !remote_o) |=> talk_o)
    else $error("talker refused in local");

endmodule

// ### remote_local_pkg.sv
/*
  Constants for the remote/local control block: register offsets,
  field positions, reset values and the master/slave role encoding.
  Assumes a single system clock and a plain strobe register port.
*/
//--------------------------------------------------------------
// Contract
//--------------------------------------------------------------
// Contract
// - Accepted local key leaves remote state
// - In remote, only local key works
// - Local key clears remote lamp, message
// - Lockout makes local key do nothing
// - Remote entered only when listened with REN
// - IFC: local, talker idle, listener idle
// - Lockout disables all panel keys
// - GTL leaves remote; lockout still holds
// - Lockout cancelled only by REN false
// - DCL restores defaults, keeps bus address
// - SDC clears only when addressed listener
// - GET triggers only with GET source
// - Serial poll always returns status byte
// - Talker works regardless of remote state
// - Bus address defaults to eighteen
// - Defaults use full single-talk format
// - Restore defaults keeps bus address
// - Power-up standalone; slave on loop init
// - Clears keep role, still clear slaves
package remote_local_pkg;

  //------------------------------------------------------------
  // Register offsets (byte addresses)
  //------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;   // Config, read/write
  localparam logic [3:0] OFS_STATUS = 4'h4; // State, read only
  localparam logic [3:0] OFS_CMD = 4'h8;    // Commands, write only
  localparam logic [3:0] OFS_SPOLL = 4'hc;  // Last poll byte

  //------------------------------------------------------------
  // Field positions
  //------------------------------------------------------------
  localparam int CTRL_ADDR_LO = 0;   // Bus address, 5 bits
  localparam int CTRL_TRIG_LO = 5;   // Trigger source, 3 bits
  localparam int CTRL_FMT_BIT = 8;   // Output format
  localparam int CTRL_MSTR_BIT = 9;  // Configured as master
  localparam int CMD_RESTORE_BIT = 0; // Restore factory defaults
  localparam int CMD_MSG_ON_BIT = 1;  // User message shown
  localparam int CMD_MSG_OFF_BIT = 2; // Display back to normal
  localparam int STS_REMOTE_BIT = 0;
  localparam int STS_LOCK_BIT = 1;
  localparam int STS_TALK_BIT = 2;
  localparam int STS_LISTEN_BIT = 3;
  localparam int STS_MSG_BIT = 4;
  localparam int STS_ROLE_LO = 5;    // Role, 2 bits

  //------------------------------------------------------------
  // Reset and default values
  //------------------------------------------------------------
  localparam logic [4:0] RST_BUS_ADDR = 5'h12;    // Decimal 18
  localparam logic [2:0] RST_TRIG_SRC = 3'h7;     // External trigger
  localparam logic [2:0] TRIG_SRC_GET = 3'h2;     // GET source code
  localparam logic FULL_SINGLE_TALK_FORMAT = 1'b0;

  // Master/slave role
  typedef enum logic [1:0] {
    ROLE_STANDALONE = 2'b00,
    ROLE_SLAVE = 2'b01,
    ROLE_MASTER = 2'b10
  } role_t;

endpackage

// ### bus_ctrl_model.sv
/*
  Bus controller model: drives the REN and IFC pin levels and the
  decoded command pulses toward the remote/local block.
  Assumes the block samples pulses on the rising clock edge and
  synchronises REN and IFC itself.
*/
`timescale 1ns/10ps
module bus_ctrl_model (
  input wire logic clk_sys_i,
  output logic ren_o,
  output logic ifc_o,
  output logic [9:0] cmd_o
);
  // ------------------------------------------------------------
  // Idle levels
  // ------------------------------------------------------------
  initial begin
    ren_o = 1'b0;
    ifc_o = 1'b0;
    cmd_o = 10'h000;
  end

  // ------------------------------------------------------------
  // Requests
  // ------------------------------------------------------------
  // REN first, listen addressing later; waits out the synchroniser
  task automatic set_ren(input logic v);
    @(posedge clk_sys_i);
    ren_o <= v;
    repeat (4) @(posedge clk_sys_i);
  endtask

  // IFC held long enough to pass the pin synchroniser
  task automatic send_ifc();
    @(posedge clk_sys_i);
    ifc_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    ifc_o <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask

  // One-cycle pulse on one decoded command line
  task automatic pulse(input int idx);
    @(posedge clk_sys_i);
    cmd_o[idx] <= 1'b1;
    @(posedge clk_sys_i);
    cmd_o[idx] <= 1'b0;
  endtask
endmodule

// ### tb.sv
/*
  Self-checking bench for the remote/local control block.
  Assumes the bus controller model drives the bus pins and the
  bench drives the register port and the front panel.
*/
`timescale 1ns/10ps
module tb;
  import remote_local_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int C_MLA = 0;
  localparam int C_MTA = 1;
  localparam int C_UNL = 2;
  localparam int C_UNT = 3;
  localparam int C_LLO = 4;
  localparam int C_GTL = 5;
  localparam int C_DCL = 6;
  localparam int C_SDC = 7;
  localparam int C_GET = 8;
  localparam int C_SP = 9;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0; // Read strobe one cycle late
  logic ms_init = 1'b0;
  logic local_key = 1'b0;
  logic [7:0] panel = 8'h00;
  logic [7:0] sp_stat = 8'h00;
  logic ren, ifc;
  logic [9:0] cmd;
  logic [31:0] rdata;
  logic remote, lockout, talk, listen, disp_norm, defaults, slave_clr, trig, spoll_vld, fmt;
  logic [7:0] keys, spoll_byte;
  logic [4:0] bus_addr;
  logic [2:0] trig_src;
  logic [1:0] role;
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  int n_errors = 0;
  int total_checks = 0;
  int n_disp = 0, n_def = 0, n_clr = 0, n_trig = 0, n_vld = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  bus_ctrl_model ctl (.clk_sys_i(clk_sys_i), .ren_o(ren), .ifc_o(ifc), .cmd_o(cmd));

  remote_local_ctrl DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ren_i(ren), .ifc_i(ifc), .mla_i(cmd[0]), .mta_i(cmd[1]),
    .unl_i(cmd[2]), .unt_i(cmd[3]), .cmd_llo_i(cmd[4]), .cmd_gtl_i(cmd[5]), .cmd_dcl_i(cmd[6]),
    .cmd_sdc_i(cmd[7]), .cmd_get_i(cmd[8]), .spoll_req_i(cmd[9]), .spoll_status_i(sp_stat),
    .ms_init_i(ms_init), .local_key_i(local_key), .panel_keys_i(panel), .remote_o(remote),
    .lockout_o(lockout), .talk_o(talk), .listen_o(listen), .keys_o(keys), .disp_norm_o(disp_norm),
    .defaults_o(defaults), .slave_clr_o(slave_clr), .trig_o(trig), .spoll_byte_o(spoll_byte),
    .spoll_vld_o(spoll_vld), .bus_addr_o(bus_addr), .trig_src_o(trig_src), .fmt_o(fmt), .role_o(role));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  // Notes the expectation; the monitor compares it later
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    rd <= 1'b0;
  endtask

  // Press held past the three-stage edge detector
  task automatic press_key();
    @(posedge clk_sys_i);
    local_key <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    local_key <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Monitor: read data and pulse counts
  // ------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (rd_d === 1'b1) begin
      check(rdata, exp_q.pop_front(), "rdata"); // Read data only stands one cycle
    end
    rd_d <= rd;
    n_disp += int'(disp_norm === 1'b1);
    n_def += int'(defaults === 1'b1);
    n_clr += int'(slave_clr === 1'b1);
    n_trig += int'(trig === 1'b1);
    n_vld += int'(spoll_vld === 1'b1);
  end

  // Watchdog, far beyond the under two hundred cycles the tests need
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(95));
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    panel <= 8'($urandom);
    rd_reg(OFS_CTRL, 32'h0f2);
    rd_reg(OFS_STATUS, 32'h00);
    check(32'(role), 32'(ROLE_STANDALONE), "role");
    check(32'(bus_addr), 32'(RST_BUS_ADDR), "bus_addr");
    ctl.set_ren(1'b1);
    rd_reg(OFS_STATUS, 32'h00);
    check(32'(remote), 32'h0, "remote");
    ctl.pulse(C_MLA);
    rd_reg(OFS_STATUS, 32'h09);
    check(32'(keys), 32'h0, "keys");
    press_key();
    rd_reg(OFS_STATUS, 32'h08);
    check(32'(keys), 32'(panel), "keys");
    ctl.pulse(C_MTA);
    rd_reg(OFS_STATUS, 32'h04);
    check(32'({talk, listen}), 32'h2, "talk_listen");
    // Untalk drops the talker again
    ctl.pulse(C_UNT);
    rd_reg(OFS_STATUS, 32'h00);
    // Message shown, then cleared by the key
    wr_reg(OFS_CMD, 32'h2);
    ctl.pulse(C_MLA);
    rd_reg(OFS_STATUS, 32'h19);
    press_key();
    rd_reg(OFS_STATUS, 32'h08);
    check(32'(n_disp), 32'h1, "disp_norm");
    // Lockout, key refused, go-to-local, REN release
    ctl.pulse(C_LLO);
    rd_reg(OFS_STATUS, 32'h0a);
    check(32'(lockout), 32'h1, "lockout");
    check(32'(keys), 32'h0, "keys");
    ctl.pulse(C_MLA);
    press_key();
    rd_reg(OFS_STATUS, 32'h0b);
    check(32'(remote), 32'h1, "remote");
    ctl.pulse(C_GTL);
    rd_reg(OFS_STATUS, 32'h0a);
    check(32'(keys), 32'h0, "keys");
    ctl.pulse(C_MLA);
    ctl.set_ren(1'b0);
    rd_reg(OFS_STATUS, 32'h08);
    check(32'({remote, lockout}), 32'h0, "remote_lockout");
    ctl.set_ren(1'b1);
    ctl.pulse(C_MLA);
    ctl.send_ifc();
    rd_reg(OFS_STATUS, 32'h00);
    check(32'({remote, talk, listen}), 32'h0, "ifc_state");
    // Serial poll while idle and not requesting service
    @(posedge clk_sys_i);
    sp_stat <= 8'($urandom);
    ctl.pulse(C_SP);
    repeat (2) @(posedge clk_sys_i);
    check(32'(n_vld), 32'h1, "spoll_vld");
    check(32'(spoll_byte), 32'(sp_stat), "spoll_byte");
    rd_reg(OFS_SPOLL, 32'(sp_stat));
    // Trigger source gates GET
    ctl.pulse(C_MLA);
    ctl.pulse(C_GET);
    repeat (2) @(posedge clk_sys_i);
    check(32'(n_trig), 32'h0, "trig");
    wr_reg(OFS_CTRL, 32'h052);
    ctl.pulse(C_GET);
    repeat (2) @(posedge clk_sys_i);
    check(32'(n_trig), 32'h1, "trig");
    wr_reg(OFS_CTRL, 32'h145);
    wr_reg(OFS_CMD, 32'h1);
    rd_reg(OFS_CTRL, 32'h0e5);
    // Device clear keeps address and master role
    wr_reg(OFS_CTRL, 32'h345);
    ctl.pulse(C_DCL);
    rd_reg(OFS_CTRL, 32'h2e5);
    check(32'(fmt), 32'(FULL_SINGLE_TALK_FORMAT), "fmt");
    check(32'(bus_addr), 32'h5, "bus_addr");
    check(32'(trig_src), 32'(RST_TRIG_SRC), "trig_src");
    check(32'(role), 32'(ROLE_MASTER), "role");
    check(32'(n_def), 32'h1, "defaults");
    check(32'(n_clr), 32'h1, "slave_clr");
    wr_reg(OFS_CTRL, 32'h0e5);
    @(posedge clk_sys_i);
    ms_init <= 1'b1;
    @(posedge clk_sys_i);
    ms_init <= 1'b0;
    @(posedge clk_sys_i);
    check(32'(role), 32'(ROLE_SLAVE), "role");
    // Selective clear only when addressed to listen
    ctl.pulse(C_MTA);
    ctl.pulse(C_SDC);
    repeat (2) @(posedge clk_sys_i);
    check(32'(n_def), 32'h1, "defaults");
    ctl.pulse(C_MLA);
    ctl.pulse(C_SDC);
    repeat (2) @(posedge clk_sys_i);
    check(32'(n_def), 32'h2, "defaults");
    check(32'(n_clr), 32'h2, "slave_clr");
    check(32'(role), 32'(ROLE_SLAVE), "role");
    // Unlisten drops the listener, remote and role stay
    ctl.pulse(C_UNL);
    rd_reg(OFS_STATUS, 32'h21);
    rd_reg(4'h1, 32'h0);
    // Power up again while configured as a slave
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd_reg(OFS_STATUS, 32'h00);
    check(32'(role), 32'(ROLE_STANDALONE), "role");
    check(32'(bus_addr), 32'(RST_BUS_ADDR), "bus_addr");
    repeat (3) @(posedge clk_sys_i);
    give_verdict();
  end
endmodule
